// ### sep_pkg.sv
package sep_pkg;
  // instruction codes, one-hot
  typedef enum logic [18:0] {
    SEP_IDLE_STEP            = 19'h00001,
    SEP_RISE_DETECT_LOAD     = 19'h00002,
    SEP_RISE_DETECT_SERIES   = 19'h00004,
    SEP_RISE_DETECT_PARALLEL = 19'h00008,
    SEP_FALL_DETECT_LOAD     = 19'h00010,
    SEP_FALL_DETECT_SERIES   = 19'h00020,
    SEP_FALL_DETECT_PARALLEL = 19'h00040,
    SEP_STORED_RISE_LOAD     = 19'h00080,
    SEP_STORED_RISE_SERIES   = 19'h00100,
    SEP_STORED_RISE_PARALLEL = 19'h00200,
    SEP_STORED_FALL_LOAD     = 19'h00400,
    SEP_STORED_FALL_SERIES   = 19'h00800,
    SEP_STORED_FALL_PARALLEL = 19'h01000,
    SEP_RISE_PULSE_OUTPUT    = 19'h02000,
    SEP_FALL_PULSE_OUTPUT    = 19'h04000,
    SEP_NEGATE_RESULT        = 19'h08000,
    SEP_RISE_HOLD_RESULT     = 19'h10000,
    SEP_FALL_HOLD_RESULT     = 19'h20000,
    SEP_LOAD_CONTACT         = 19'h40000
  } sep_op_e;
  localparam int  SEP_SLOT_W   = 4;      // index width for the 16 program positions with own history
  localparam int  SEP_SLOTS    = 16;
  localparam logic SEP_ACC_RST = 1'b0;
  localparam logic SEP_HIST_RST = 1'b0;
endpackage

// ### sep_scan_edge_pulse_logic.sv
`timescale 1ns/100ps
module sep_scan_edge_pulse_logic import sep_pkg::*; (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  input  wire logic                  step_valid,
  input  wire sep_op_e               step_op,
  input  wire logic [SEP_SLOT_W-1:0] step_slot,
  input  wire logic                  contact,
  input  wire logic                  prev_in,
  output logic                       acc_out,
  output logic                       stack_out,
  output logic                       dest_out,
  output logic                       dest_valid,
  output logic                       prev_out,
  output logic                       prev_write
);
  // internal history per program position, and result registers
  logic [SEP_SLOTS-1:0] hist_reg;
  logic [SEP_SLOTS-1:0] hist_next;
  logic                 acc_reg;
  logic                 acc_next;
  logic                 stk_reg;
  logic                 stk_next;
  logic                 dst_reg;
  logic                 dst_next;
  logic                 dv_reg;
  logic                 dv_next;
  logic                 pw_reg;
  logic                 pw_next;
  logic                 po_reg;
  logic                 po_next;

  function automatic logic rose(input logic prev, input logic now);
    rose = ~prev & now;
  endfunction
  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction

  // one instruction per enabled step; history only touched by its owner
  always_comb begin
    logic h;
    h = hist_reg[step_slot];
    hist_next = hist_reg;
    acc_next = acc_reg;
    stk_next = stk_reg;
    dst_next = dst_reg;
    dv_next = 1'b0;
    pw_next = 1'b0;
    po_next = po_reg;
    if (step_valid) begin
      unique case (step_op)
        SEP_IDLE_STEP: ;
        SEP_LOAD_CONTACT: begin
          stk_next = acc_reg;
          acc_next = contact;
        end
        SEP_RISE_DETECT_LOAD: begin
          stk_next = acc_reg;
          acc_next = rose(h, contact);
          hist_next[step_slot] = contact;
        end
        SEP_RISE_DETECT_SERIES: begin
          acc_next = acc_reg & rose(h, contact);
          hist_next[step_slot] = contact;
        end
        SEP_RISE_DETECT_PARALLEL: begin
          acc_next = acc_reg | rose(h, contact);
          hist_next[step_slot] = contact;
        end
        SEP_FALL_DETECT_LOAD: begin
          stk_next = acc_reg;
          acc_next = fell(h, contact);
          hist_next[step_slot] = contact;
        end
        SEP_FALL_DETECT_SERIES: begin
          acc_next = acc_reg & fell(h, contact);
          hist_next[step_slot] = contact;
        end
        SEP_FALL_DETECT_PARALLEL: begin
          acc_next = acc_reg | fell(h, contact);
          hist_next[step_slot] = contact;
        end
        SEP_STORED_RISE_LOAD: begin
          stk_next = acc_reg;
          acc_next = rose(prev_in, contact);
          pw_next = 1'b1;
          po_next = contact;
        end
        SEP_STORED_RISE_SERIES: begin
          acc_next = acc_reg & rose(prev_in, contact);
          pw_next = 1'b1;
          po_next = contact;
        end
        SEP_STORED_RISE_PARALLEL: begin
          acc_next = acc_reg | rose(prev_in, contact);
          pw_next = 1'b1;
          po_next = contact;
        end
        SEP_STORED_FALL_LOAD: begin
          stk_next = acc_reg;
          acc_next = fell(prev_in, contact);
          pw_next = 1'b1;
          po_next = contact;
        end
        SEP_STORED_FALL_SERIES: begin
          acc_next = acc_reg & fell(prev_in, contact);
          pw_next = 1'b1;
          po_next = contact;
        end
        SEP_STORED_FALL_PARALLEL: begin
          acc_next = acc_reg | fell(prev_in, contact);
          pw_next = 1'b1;
          po_next = contact;
        end
        SEP_RISE_PULSE_OUTPUT: begin
          dst_next = rose(h, acc_reg);
          dv_next = 1'b1;
          hist_next[step_slot] = acc_reg;
        end
        SEP_FALL_PULSE_OUTPUT: begin
          dst_next = fell(h, acc_reg);
          dv_next = 1'b1;
          hist_next[step_slot] = acc_reg;
        end
        SEP_NEGATE_RESULT: acc_next = ~acc_reg;
        SEP_RISE_HOLD_RESULT: begin
          acc_next = rose(h, acc_reg);
          hist_next[step_slot] = acc_reg;
        end
        SEP_FALL_HOLD_RESULT: begin
          acc_next = fell(h, acc_reg);
          hist_next[step_slot] = acc_reg;
        end
        default: acc_next = acc_reg; // illegal code keeps state
      endcase
    end
  end

  // registers advance only on a cycle with clk_en high, with or without step_valid
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hist_reg <= {SEP_SLOTS{SEP_HIST_RST}};
      acc_reg  <= SEP_ACC_RST;
      stk_reg  <= SEP_ACC_RST;
      dst_reg  <= 1'b0;
      dv_reg   <= 1'b0;
      pw_reg   <= 1'b0;
      po_reg   <= 1'b0;
    end else if (clk_en) begin
      hist_reg <= hist_next;
      acc_reg  <= acc_next;
      stk_reg  <= stk_next;
      dst_reg  <= dst_next;
      dv_reg   <= dv_next;
      pw_reg   <= pw_next;
      po_reg   <= po_next;
    end
  end

  assign acc_out    = acc_reg;
  assign stack_out  = stk_reg;
  assign dest_out   = dst_reg;
  assign dest_valid = dv_reg;
  assign prev_out   = po_reg;
  assign prev_write = pw_reg;

  AST_NEGATE: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_NEGATE_RESULT |=> acc_out == !$past(acc_out))
    else $error("negate did not invert");
  AST_IDLE: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_IDLE_STEP |=> $stable(acc_out))
    else $error("idle step changed accumulator");
  AST_SRISE_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_STORED_RISE_LOAD
    |=> acc_out == ($past(contact) && !$past(prev_in)) && stack_out == $past(acc_out))
    else $error("stored rise load wrong");
  AST_SRISE_SER: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_STORED_RISE_SERIES && !acc_out |=> !acc_out)
    else $error("stored rise series ignored accumulator");
  AST_SRISE_PAR: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_STORED_RISE_PARALLEL && acc_out |=> acc_out)
    else $error("stored rise parallel ignored accumulator");
  AST_SFALL_SER: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_STORED_FALL_SERIES
    |=> acc_out == ($past(acc_out) && $past(prev_in) && !$past(contact)))
    else $error("stored fall series wrong");
  AST_SFALL_PAR: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_STORED_FALL_PARALLEL
    |=> acc_out == ($past(acc_out) || ($past(prev_in) && !$past(contact))))
    else $error("stored fall parallel wrong");
  AST_PREV_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_STORED_FALL_LOAD |=> prev_write && prev_out == $past(contact))
    else $error("previous state not written back");
  AST_PULSE_DV: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_RISE_PULSE_OUTPUT
    |=> dest_valid && dest_out == ($past(acc_out) && !$past(hist_reg[step_slot])))
    else $error("rise pulse output wrong");
  AST_FALL_PULSE: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_FALL_PULSE_OUTPUT
    |=> dest_valid && dest_out == (!$past(acc_out) && $past(hist_reg[step_slot])))
    else $error("fall pulse output wrong");
  AST_RISE_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_RISE_HOLD_RESULT
    |=> acc_out == ($past(acc_out) && !$past(hist_reg[step_slot])))
    else $error("rise hold wrong");
  AST_RISE_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && step_valid && step_op == SEP_RISE_DETECT_LOAD
    |=> stack_out == $past(acc_out) && acc_out == ($past(contact) && !$past(hist_reg[step_slot])))
    else $error("rise detect load wrong");
  AST_FREEZE: assert property (@(posedge mclk) disable iff (!nrst)
    !clk_en |=> $stable(acc_out) && $stable(stack_out) && $stable(prev_write) && $stable(dest_valid))
    else $error("state moved while clock enable low");
endmodule

// ### sep_seq_model.sv
`timescale 1ns/100ps
// previous_state_bit store kept by the scan sequencer
module sep_seq_model import sep_pkg::*; (
  input  wire logic                  mclk,
  input  wire logic                  take,
  input  wire logic [SEP_SLOT_W-1:0] step_slot,
  input  wire logic                  prev_out,
  input  wire logic                  prev_write,
  output logic                       prev_in
);
  logic [SEP_SLOTS-1:0]  bits_reg = '0;
  logic [SEP_SLOT_W-1:0] wslot_reg = '0;
  // own bit per slot; a write still landing is forwarded to its reader
  assign prev_in = (prev_write && wslot_reg == step_slot) ? prev_out : bits_reg[step_slot];
  // the write lands in the slot of the op that asked for it
  always @(posedge mclk) begin
    if (take) wslot_reg <= step_slot;
    if (prev_write) bits_reg[wslot_reg] <= prev_out;
  end
endmodule

// ### sep_scan_edge_pulse_logic_tb.sv
`timescale 1ns/100ps
module sep_scan_edge_pulse_logic_tb import sep_pkg::*; ;
  logic                  mclk = 1'b0, nrst = 1'b0, clk_en = 1'b0, step_valid = 1'b0, contact = 1'b0;
  sep_op_e               step_op = SEP_IDLE_STEP;
  logic [SEP_SLOT_W-1:0] step_slot = '0;
  logic                  prev_in, acc_out, stack_out, dest_out, dest_valid, prev_out, prev_write;
  logic                  acc = SEP_ACC_RST, stk = 1'b0;
  logic [SEP_SLOTS-1:0]  hist = '0, pbit = '0;
  int                    n_errors = 0, compares = 0;
  // clock
  always #25 mclk = ~mclk;
  sep_scan_edge_pulse_logic u_sep_scan_edge_pulse_logic (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
    .step_valid(step_valid), .step_op(step_op), .step_slot(step_slot), .contact(contact), .prev_in(prev_in),
    .acc_out(acc_out), .stack_out(stack_out), .dest_out(dest_out), .dest_valid(dest_valid),
    .prev_out(prev_out), .prev_write(prev_write));
  sep_seq_model u_sep_seq_model (.mclk(mclk), .take(clk_en & step_valid), .step_slot(step_slot),
    .prev_out(prev_out), .prev_write(prev_write), .prev_in(prev_in));
  // compare one value
  task chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // edge of a level against its old value
  function automatic logic edg(input logic cur, input logic old, input logic fall);
    return fall ? (~cur & old) : (cur & ~old);
  endfunction
  // verdict and end of run
  task complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one step: drive at falling edge, model, check one cycle later
  task automatic step(input int i, input logic [3:0] s, input logic c, input logic en);
    logic e;
    logic d;
    step_op = sep_op_e'(19'h1 << i);
    step_slot = s;
    contact = c;
    clk_en = en;
    step_valid = 1'b1;
    e = 1'b0;
    d = 1'b0;
    if (en) begin
      if (i >= 1 && i <= 6) begin
        e = edg(c, hist[s], i > 3);
        hist[s] = c;
      end else if (i >= 7 && i <= 12) begin
        e = edg(c, pbit[s], i > 9);
        pbit[s] = c;
      end
      if (i >= 1 && i <= 12) begin
        if ((i - 1) % 3 == 0) stk = acc;
        acc = ((i - 1) % 3 == 0) ? e : ((i - 1) % 3 == 1) ? (acc & e) : (acc | e);
      end
      if (i >= 13 && i <= 17 && i != 15) begin
        e = edg(acc, hist[s], i == 14 || i == 17);
        hist[s] = acc;
        if (i >= 16) acc = e;
        else d = e;
      end
      if (i == 15) acc = ~acc;
      if (i == 18) begin
        stk = acc;
        acc = c;
      end
    end
    @(negedge mclk);
    chk(acc_out, acc);
    if (en) begin
      chk(prev_write, i >= 7 && i <= 12);
      chk(dest_valid, i == 13 || i == 14);
      if (i >= 7 && i <= 12) chk(prev_out, c);
      if (i == 13 || i == 14) chk(dest_out, d);
      if ((i >= 1 && i <= 12 && (i - 1) % 3 == 0) || i == 18) chk(stack_out, stk);
    end
  endtask
  // corner cases, then random steps
  initial begin
    int                    op;
    logic [SEP_SLOT_W-1:0] sl;
    void'($urandom(32'h2341CB38));
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    for (int i = 0; i < 19; i++) begin
      for (int k = 0; k < 4; k++) step(i, 4'(i), k == 1 || k == 2, 1'b1);
    end
    for (int b = 1; b <= 10; b += 3) begin
      for (int k = 0; k < 16; k++) begin
        // each detect and stored edge op keeps its own slot, so no history or previous bit is shared
        step(b, 4'(b), k[0], 1'b1);
        step(b + 1, 4'(b + 1), k[1], 1'b1);
        step(b + 2, 4'(b + 2), k[2], 1'b1);
      end
    end
    repeat (600) begin
      op = $urandom_range(18);
      sl = (op >= 7 && op <= 12) ? 4'(op) : 4'($urandom_range(15));
      step(op, sl, 1'($urandom_range(1)), $urandom_range(3) != 0);
    end
    complete_run;
  end
  // watchdog
  initial begin
    #(4000 * 50);
    n_errors++;
    complete_run;
  end
endmodule
